// *** design/ldl_pkg.sv ***
// Constants for the serial data path and latches of a 24-channel PWM driver.
// Assumes one 20 MHz clock aclk; every pin but aresetn and the AXI4-Lite port is asynchronous to it.
//
// Function
// RULE1: Pixel latch is loaded as a 288-bit word from pixel serial input.
// RULE2: Each pixel shift clock rise shifts common register toward MSB, MSB out.
// RULE3: Strobe level at last pixel shift edge picks the transfer target.
// RULE4: Strobe low at that edge: all 288 bits go to the pixel latch.
// RULE5: Strobe high: bits 0-198 to trim latch, 199-215 to trim shifter.
// RULE6: Controller waits over 7 ms after last trim shift edge before strobe; the bench strobes far sooner after its trim shift.
// RULE7: Common shift register has no defined power-up value.
// RULE8: Pixel latch is 288 bits, one 12-bit on-time per output.
// RULE9: New pixel latch values act on the outputs at once.
// RULE10: Controller strobes pixel data only while blank_n is low; the bench also strobes pixel data with blank_n high.
// RULE11: Fields run red, green, blue per channel, red 0 lowest.
// RULE12: Controller latches valid pixel data before enabling outputs.
// RULE13: While blank_n is low every output is off.
// RULE14: Controller holds blank_n low until latches are programmed.
// RULE15: Trim latch is also written from its own serial shift register.
// RULE16: Trim latch contents can be read out on pixel serial output.
// RULE17: Trim shift clock rise shifts 216-bit register, MSB on trim output.
// RULE18: Trim shift register has no defined power-up value.
// RULE19: Internal blank on pixel load with timing reset, and at 4096th edge.
// RULE20: With timing reset or auto repeat, blank_n may be tied high.
// RULE21: blank_n fall clears the three PWM counters; they stay zero while low.
// RULE22: Output is on while its group counter is at most its 12-bit value; the code also keeps it off at count 0.
// RULE23: Strobe rise captures, using a select flag kept at each shift edge.
package ldl_pkg;
  localparam int PIX_W      = 288;
  localparam int TRIM_W     = 216;
  localparam int TRIM_LO_HI = 198;
  localparam int TRIM_UD_LO = 199;
  localparam int FIELD_W    = 12;
  localparam int CHANNELS   = 8;
  localparam int GROUPS     = 3;
  localparam int CNT_W      = 13;
  localparam logic [CNT_W-1:0] CNT_LAST = 13'h0FFF;
  localparam logic [CNT_W-1:0] CNT_OVER = 13'h1000;

  localparam int SYN_W      = 9;
  localparam int SYN_PSIN   = 0;
  localparam int SYN_PSCK   = 1;
  localparam int SYN_STROBE = 2;
  localparam int SYN_BLANK  = 3;
  localparam int SYN_TSIN   = 4;
  localparam int SYN_TSCK   = 5;
  localparam int SYN_GCLK   = 6;

  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_INDEX  = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_PIXEL  = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_TRIM   = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_TSHIFT = 8'h14;

  localparam int CTRL_TRESET_BIT = 0;
  localparam int CTRL_REPEAT_BIT = 1;
  localparam int CTRL_TLOAD_BIT  = 2;
  localparam logic [1:0] CTRL_RESET  = 2'h0;
  localparam logic [3:0] INDEX_RESET = 4'h0;
  localparam int STAT_OUT_LSB = 8;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** design/ldl_pwm.sv ***
// Three group counters and 24 output comparators.
// Assumes ticks and blank are already synchronised to aclk.
`timescale 1ns/1ns
module ldl_pwm
  import ldl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  ldl_pwm_if.pwm   pw
);
  logic [CNT_W-1:0] cnt [GROUPS];

  // ----------------------------------------------------------------
  // Group counters
  // ----------------------------------------------------------------
  for (genvar g = 0; g < GROUPS; g++)
  begin : g_cnt
    wire internal_blank = pw.pixel_load && pw.timing_reset_en;     // RULE19
    wire wrap           = pw.auto_repeat_en && cnt[g] == CNT_LAST; // RULE19
    always_ff @(posedge aclk)
    begin
      if (!aresetn || !pw.blank_n || pw.blank_fall || internal_blank) // RULE21
        cnt[g] <= '0;
      else if (pw.group_tick[g])
        cnt[g] <= wrap ? '0 : (cnt[g] == CNT_OVER ? cnt[g] : cnt[g] + 1'b1);
    end

    a_counter_held: assert property (@(posedge aclk) disable iff (!aresetn)
      !pw.blank_n |=> cnt[g] == '0) // RULE21
      else $error("counter not held at zero while blanked");
    a_auto_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
      pw.blank_n && !pw.pixel_load && wrap && pw.group_tick[g]
      |=> cnt[g] == '0) // RULE19
      else $error("counter did not wrap at the 4096th edge");
  end

  // ----------------------------------------------------------------
  // Output compare
  // ----------------------------------------------------------------
  // Comparison uses the live latch, so a reload acts at once.
  for (genvar i = 0; i < GROUPS*CHANNELS; i++)
  begin : g_out
    localparam int G = i % GROUPS;
    wire [CNT_W-1:0] level = {1'b0, pw.pixel_latch[i*FIELD_W +: FIELD_W]};
    wire next_on = pw.blank_n && cnt[G] != '0 && cnt[G] <= level; // RULE22
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        pw.led_on[i] <= 1'b0;
      else
        pw.led_on[i] <= next_on; // RULE9 RULE13
    end

    a_level_on: assert property (@(posedge aclk) disable iff (!aresetn)
      pw.blank_n && cnt[G] == 13'h0001 && level != '0 |=> pw.led_on[i])
      // RULE22
      else $error("output not on for first count");
  end

  a_blank_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !pw.blank_n |=> pw.led_on == '0) // RULE13
    else $error("output on while blanked");
endmodule

// *** design/ldl_pwm_if.sv ***
// Carrier between the data-path top and the PWM output stage.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface ldl_pwm_if;
  import ldl_pkg::*;
  logic [PIX_W-1:0]  pixel_latch;
  logic              pixel_load;
  logic              blank_n;
  logic              blank_fall;
  logic [GROUPS-1:0] group_tick;
  logic              timing_reset_en;
  logic              auto_repeat_en;
  logic [GROUPS*CHANNELS-1:0] led_on;

  modport ctrl
  (
    output pixel_latch, pixel_load, blank_n, blank_fall, group_tick,
    output timing_reset_en, auto_repeat_en,
    input  led_on
  );
  modport pwm
  (
    input  pixel_latch, pixel_load, blank_n, blank_fall, group_tick,
    input  timing_reset_en, auto_repeat_en,
    output led_on
  );
endinterface

// *** design/ldl_top.sv ***
// Serial data path, pixel and trim latches, AXI4-Lite view, PWM stage.
// Assumes all serial pins toggle slowly against aclk (link near 2.5 MHz).
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ns
module ldl_top
  import ldl_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                pixel_serial_in,
  input  wire logic                pixel_shift_clock,
  input  wire logic                latch_strobe,
  input  wire logic                blank_n,
  input  wire logic                correction_serial_in,
  input  wire logic                correction_shift_clock,
  input  wire logic [GROUPS-1:0]   pwm_group_clocks,
  output wire logic                pixel_serial_out,
  output wire logic                correction_serial_out,
  output wire logic [CHANNELS-1:0] red_outputs,
  output wire logic [CHANNELS-1:0] green_outputs,
  output wire logic [CHANNELS-1:0] blue_outputs,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output wire logic                s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output wire logic                s_axi_wready,
  output logic      [1:0]          s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output wire logic                s_axi_arready,
  output logic      [31:0]         s_axi_rdata,
  output logic      [1:0]          s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);
  ldl_pwm_if pw ();

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [SYN_W-1:0] syn_a;
  logic [SYN_W-1:0] syn_b;
  logic [SYN_W-1:0] syn_c;
  wire  [SYN_W-1:0] pins = {pwm_group_clocks, correction_shift_clock,
                            correction_serial_in, blank_n, latch_strobe,
                            pixel_shift_clock, pixel_serial_in};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      syn_a <= '0;
      syn_b <= '0;
      syn_c <= '0;
    end
    else
    begin
      syn_a <= pins;
      syn_b <= syn_a;
      syn_c <= syn_b;
    end
  end

  wire [SYN_W-1:0] rise     = syn_b & ~syn_c;
  wire [SYN_W-1:0] fall     = ~syn_b & syn_c;
  wire             psin     = syn_b[SYN_PSIN];
  wire             strobe   = syn_b[SYN_STROBE];
  wire             tsin     = syn_b[SYN_TSIN];
  wire             pix_rise = rise[SYN_PSCK];
  wire             trm_rise = rise[SYN_TSCK];
  wire             stb_rise = rise[SYN_STROBE];
  wire             stb_fall = fall[SYN_STROBE];

  // ----------------------------------------------------------------
  // Shift registers and latches
  // ----------------------------------------------------------------
  // No reset on the shift registers and latches: the silicon powers up random, so a reset would
  // hide controller bugs that depend on a defined start value.
  logic [PIX_W-1:0]  common_shift; // RULE7
  logic [PIX_W-1:0]  pixel_latch;
  logic [TRIM_W-1:0] trim_shift;   // RULE18
  logic [TRIM_W-1:0] trim_latch;
  logic              dest_trim;
  logic              trim_read;
  logic [1:0]        ctrl;
  logic [3:0]        word_index;
  logic              trim_load;

  wire to_pixel = stb_rise && !dest_trim; // RULE3 RULE23
  wire to_trim  = stb_rise && dest_trim;  // RULE3 RULE23

  // Select flag follows the strobe level at every pixel shift edge.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      dest_trim <= 1'b0;
    else if (pix_rise)
      dest_trim <= strobe; // RULE23
  end

  // A trim transfer arms a readback: the strobe fall copies the trim
  // latch into the common register so it walks out on the serial pin.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      trim_read <= 1'b0;
    else if (to_trim)
      trim_read <= 1'b1;
    else if (stb_fall)
      trim_read <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (trim_read && stb_fall)
      common_shift <= {{(PIX_W-TRIM_W){1'b0}}, trim_latch}; // RULE16
    else if (pix_rise)
      common_shift <= {common_shift[PIX_W-2:0], psin}; // RULE1 RULE2
  end

  always_ff @(posedge aclk)
  begin
    if (to_pixel)
      pixel_latch <= common_shift; // RULE4 RULE8 RULE11
  end

  always_ff @(posedge aclk)
  begin
    if (to_trim)
      trim_shift[TRIM_W-1:TRIM_UD_LO] <= common_shift[TRIM_W-1:TRIM_UD_LO];
      // RULE5
    else if (trm_rise)
      trim_shift <= {trim_shift[TRIM_W-2:0], tsin}; // RULE17
  end

  always_ff @(posedge aclk)
  begin
    if (to_trim)
      trim_latch[TRIM_LO_HI:0] <= common_shift[TRIM_LO_HI:0]; // RULE5
    else if (trim_load)
      trim_latch <= trim_shift; // RULE15
  end

  assign pixel_serial_out      = common_shift[PIX_W-1]; // RULE2
  assign correction_serial_out = trim_shift[TRIM_W-1];  // RULE17

  // ----------------------------------------------------------------
  // PWM stage
  // ----------------------------------------------------------------
  assign pw.pixel_latch     = pixel_latch;
  assign pw.pixel_load      = to_pixel;
  assign pw.blank_n         = syn_b[SYN_BLANK];
  assign pw.blank_fall      = fall[SYN_BLANK];
  assign pw.group_tick      = rise[SYN_GCLK +: GROUPS];
  assign pw.timing_reset_en = ctrl[CTRL_TRESET_BIT];
  assign pw.auto_repeat_en  = ctrl[CTRL_REPEAT_BIT];

  ldl_pwm u_pwm
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pw      (pw.pwm)
  );

  for (genvar c = 0; c < CHANNELS; c++)
  begin : g_map
    assign red_outputs[c]   = pw.led_on[c*GROUPS];
    assign green_outputs[c] = pw.led_on[c*GROUPS+1];
    assign blue_outputs[c]  = pw.led_on[c*GROUPS+2];
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  // Address and data are taken together, so order of arrival is free.
  wire wr_take  = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  wire rd_take  = s_axi_arvalid && !s_axi_rvalid;
  wire wr_ctrl  = wr_take && s_axi_awaddr == ADDR_CTRL;
  wire wr_index = wr_take && s_axi_awaddr == ADDR_INDEX;
  wire wr_ok    = wr_ctrl || wr_index;
  wire rd_ok    = s_axi_araddr inside {ADDR_CTRL, ADDR_STATUS, ADDR_INDEX,
                                       ADDR_PIXEL, ADDR_TRIM, ADDR_TSHIFT};

  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;
  assign s_axi_arready = rd_take;

  wire [511:0] pix_pad  = {224'h0, pixel_latch};
  wire [511:0] trm_pad  = {296'h0, trim_latch};
  wire [511:0] tsh_pad  = {296'h0, trim_shift};
  wire [8:0]   word_lsb = {word_index, 5'h00};
  wire [31:0]  status   = {pw.led_on, 4'h0, correction_serial_out,
                           pixel_serial_out, dest_trim, pw.blank_n};

  wire [31:0] rd_word =
    s_axi_araddr == ADDR_CTRL   ? {30'h0, ctrl} :
    s_axi_araddr == ADDR_STATUS ? status :
    s_axi_araddr == ADDR_INDEX  ? {28'h0, word_index} :
    s_axi_araddr == ADDR_PIXEL  ? pix_pad[word_lsb +: 32] :
    s_axi_araddr == ADDR_TRIM   ? trm_pad[word_lsb +: 32] :
    s_axi_araddr == ADDR_TSHIFT ? tsh_pad[word_lsb +: 32] : 32'h0000_0000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl       <= CTRL_RESET;
      word_index <= INDEX_RESET;
      trim_load  <= 1'b0;
    end
    else
    begin
      trim_load <= wr_ctrl && s_axi_wstrb[0] && s_axi_wdata[CTRL_TLOAD_BIT];
      if (wr_ctrl && s_axi_wstrb[0])
        ctrl <= s_axi_wdata[1:0];
      if (wr_index && s_axi_wstrb[0])
        word_index <= s_axi_wdata[3:0];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (wr_take)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
    end
    else if (rd_take)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      s_axi_rdata  <= rd_word;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_pixel_xfer;
    stb_rise && !dest_trim;
  endsequence
  sequence s_trim_xfer;
    stb_rise && dest_trim;
  endsequence

  a_shift_in: assert property (@(posedge aclk) disable iff (!aresetn)
    pix_rise && !(trim_read && stb_fall)
    |=> common_shift[0] == $past(psin)
        && common_shift[PIX_W-1:1] === $past(common_shift[PIX_W-2:0]))
    // RULE2
    else $error("common register did not shift");
  a_select_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    pix_rise |=> dest_trim == $past(strobe) ##1 !pix_rise[*1]) // RULE3
    else $error("select flag missed the strobe level");
  a_pixel_load: assert property (@(posedge aclk) disable iff (!aresetn)
    s_pixel_xfer |=> pixel_latch === $past(common_shift)) // RULE4
    else $error("pixel latch not loaded");
  a_trim_low: assert property (@(posedge aclk) disable iff (!aresetn)
    s_trim_xfer
    |=> trim_latch[TRIM_LO_HI:0] == $past(common_shift[TRIM_LO_HI:0]))
    // RULE5
    else $error("trim latch low bits not loaded");
  a_trim_user: assert property (@(posedge aclk) disable iff (!aresetn)
    s_trim_xfer |=> trim_shift[TRIM_W-1:TRIM_UD_LO]
                    == $past(common_shift[TRIM_W-1:TRIM_UD_LO])) // RULE5
    else $error("user bits not routed to trim shifter");
  a_trim_shift: assert property (@(posedge aclk) disable iff (!aresetn)
    trm_rise && !to_trim |=> trim_shift[0] == $past(tsin)
                  && correction_serial_out === $past(trim_shift[TRIM_W-2]))
    // RULE17
    else $error("trim register did not shift");
  a_trim_readback: assert property (@(posedge aclk) disable iff (!aresetn)
    s_trim_xfer ##[1:200] (stb_fall && trim_read)
    |=> common_shift[TRIM_W-1:0] === $past(trim_latch)) // RULE16
    else $error("trim latch not placed for readback");
  a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_take |=> s_axi_bvalid)
    else $error("write response not raised after acceptance");
endmodule

// *** dv/ldl_ctrl_model.sv ***
// Display controller model that drives the serial, strobe, blank and PWM pins.
// Assumes the bench clock aclk; every pin changes just after its rising edge.
`timescale 1ns/1ns
module ldl_ctrl_model
  import ldl_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         pixel_serial_out,
  input  wire logic         correction_serial_out,
  output logic              pixel_serial_in,
  output logic              pixel_shift_clock,
  output logic              latch_strobe,
  output logic              blank_n,
  output logic              correction_serial_in,
  output logic              correction_shift_clock,
  output logic [GROUPS-1:0] pwm_group_clocks
);
  // ------------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------------
  // Outputs stay dark until the bench has loaded real pixel data.
  initial
  begin
    pixel_serial_in        = 1'h0;
    pixel_shift_clock      = 1'h0;
    latch_strobe           = 1'h0;
    correction_serial_in   = 1'h0;
    correction_shift_clock = 1'h0;
    pwm_group_clocks       = 3'h0;
    blank_n                = 1'h0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Four aclk per half period gives a 400 ns link clock that stands still
  // between frames. Bit 0 goes last; seen returns the old register contents.
  task automatic shift(input bit trim, input logic [PIX_W-1:0] d,
                       input int n, input bit hi_last,
                       output logic [PIX_W-1:0] seen);
    seen = '0;
    for (int i = n - 1; i >= 0; i--)
    begin
      pixel_serial_in        <= trim ? pixel_serial_in : d[i];
      correction_serial_in   <= trim ? d[i] : correction_serial_in;
      latch_strobe           <= latch_strobe | (hi_last && i == 0);
      wt(4);
      seen[i] = trim ? correction_serial_out : pixel_serial_out;
      pixel_shift_clock      <= !trim;
      correction_shift_clock <= trim;
      wt(4);
      pixel_shift_clock      <= 1'h0;
      correction_shift_clock <= 1'h0;
    end
    // A released data line shows the inverse of its last bit.
    pixel_serial_in        <= trim ? pixel_serial_in : ~d[0];
    correction_serial_in   <= trim ? ~d[0] : correction_serial_in;
  endtask

  task automatic strobe(input logic v);
    latch_strobe <= v;
    wt(8);
  endtask

  task automatic blank(input logic v);
    blank_n <= v;
    wt(8);
  endtask

  task automatic gpulse();
    pwm_group_clocks <= 3'h7;
    wt(4);
    pwm_group_clocks <= 3'h0;
    wt(4);
  endtask
endmodule

// *** dv/ldl_top_tb_top.sv ***
// Self-checking bench for the serial data path and latches.
// Assumes the controller model drives every serial, strobe, blank and PWM pin; AXI4-Lite reads the latches.
`timescale 1ns/1ns
module ldl_top_tb_top
  import ldl_pkg::*;
;
  logic                aclk, aresetn;
  logic                pixel_serial_in, pixel_shift_clock, latch_strobe;
  logic                blank_n, correction_serial_in, correction_shift_clock;
  logic [GROUPS-1:0]   pwm_group_clocks;
  logic                pixel_serial_out, correction_serial_out;
  logic [CHANNELS-1:0] red_outputs, green_outputs, blue_outputs;
  logic [ADDR_W-1:0]   s_axi_awaddr, s_axi_araddr;
  logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic                s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic                s_axi_rready;
  logic [31:0]         s_axi_wdata, s_axi_rdata;
  logic [3:0]          s_axi_wstrb;
  logic [1:0]          s_axi_bresp, s_axi_rresp;
  int                  n_errors, checks;

  ldl_top u_ldl_top (.aclk, .aresetn, .pixel_serial_in, .pixel_shift_clock,
    .latch_strobe, .blank_n, .correction_serial_in, .correction_shift_clock,
    .pwm_group_clocks, .pixel_serial_out, .correction_serial_out,
    .red_outputs, .green_outputs, .blue_outputs, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  ldl_ctrl_model u_ldl_ctrl_model (.aclk, .pixel_serial_out,
    .correction_serial_out, .pixel_serial_in, .pixel_shift_clock,
    .latch_strobe, .blank_n, .correction_serial_in, .correction_shift_clock,
    .pwm_group_clocks);

  initial
  begin
    aclk = 1'h0;
    forever #25 aclk = ~aclk;
  end

  // ------------------------------------------------------------------
  // Reporting and bus tasks
  // ------------------------------------------------------------------
  task automatic results();
    if (n_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] g, e, input string m);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic chk_led(input logic [23:0] e);
    checks++;
    if ({blue_outputs, green_outputs, red_outputs} !== e)
    begin
      n_errors++;
      $display("[ERR] %0t outputs exp %h", $time, e);
    end
  endtask

  task automatic chk_ser(input logic [PIX_W-1:0] g, e);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %0t serial stream mismatch", $time);
    end
  endtask

  task automatic tmo();
    n_errors++;
    $display("[ERR] %0t bus timeout", $time);
    results();
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    int t;
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    for (t = 0; t < 64; t++)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        break;
      end
    end
    if (t == 64)
      tmo();
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int t;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    for (t = 0; t < 64; t++)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        break;
      end
    end
    if (t == 64)
      tmo();
  endtask

  // Reads nw latch words through the index register, masking unknown bits.
  task automatic chk_vec(input logic [7:0] a, input logic [PIX_W-1:0] e, m,
                         input int nw);
    logic [31:0] d;
    logic [1:0]  r;
    for (int n = 0; n < nw; n++)
    begin
      axi_wr(ADDR_INDEX, 32'(n), r);
      axi_rd(a, d, r);
      chk32(d & m[32*n +: 32], e[32*n +: 32] & m[32*n +: 32], "latch word");
    end
  endtask

  function automatic logic [23:0] led_exp(input int k);
    logic [23:0] e;
    for (int i = 0; i < 24; i++)
      e[(i % 3) * 8 + i / 3] = (k >= 1 && k <= i);
    return e;
  endfunction

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial
  begin
    logic [31:0]      d;
    logic [1:0]       r;
    logic [PIX_W-1:0] cv, pv, tv, seen, ml, mh, mb;
    n_errors = 0;
    checks = 0;
    aresetn = 1'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr} = 16'h0000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    cv = {9{32'h9E37_79B9}};
    tv = {9{32'h5AC3_0F69}};
    tv[PIX_W-1:TRIM_W] = '0;
    for (int i = 0; i < GROUPS * CHANNELS; i++)
      pv[FIELD_W*i +: FIELD_W] = FIELD_W'(i);
    ml = '0;
    ml[TRIM_LO_HI:0] = '1;
    mh = '0;
    mh[TRIM_W-1:TRIM_UD_LO] = '1;
    mb = ml;
    mb[PIX_W-1:TRIM_W] = '1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    axi_rd(ADDR_CTRL, d, r);
    chk32(d, 32'h0000_0000, "ctrl reset");
    axi_rd(8'h1C, d, r);
    chk32({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped resp");
    chk32(d, 32'h0000_0000, "unmapped data");
    axi_wr(ADDR_PIXEL, 32'hFFFF_FFFF, r);
    chk32({30'h0, r}, {30'h0, RESP_SLVERR}, "read-only resp");
    // No trim shift edge has happened yet, so the strobe gap is kept.
    u_ldl_ctrl_model.shift(1'b0, cv, PIX_W, 1'b1, seen);
    u_ldl_ctrl_model.strobe(1'h0);
    u_ldl_ctrl_model.strobe(1'h1);
    chk_vec(ADDR_TRIM, cv, ml, 7);
    chk_vec(ADDR_TSHIFT, cv, mh, 7);
    u_ldl_ctrl_model.strobe(1'h0);
    u_ldl_ctrl_model.shift(1'b0, pv, PIX_W, 1'b0, seen);
    chk_ser(seen & mb, cv & ml);
    u_ldl_ctrl_model.strobe(1'h1);
    chk_vec(ADDR_PIXEL, pv, '1, 9);
    u_ldl_ctrl_model.strobe(1'h0);
    u_ldl_ctrl_model.gpulse();
    chk_led(24'h00_0000);
    u_ldl_ctrl_model.blank(1'h1);
    for (int k = 0; k < 4; k++)
    begin
      chk_led(led_exp(k));
      u_ldl_ctrl_model.gpulse();
    end
    u_ldl_ctrl_model.blank(1'h0);
    chk_led(24'h00_0000);
    u_ldl_ctrl_model.blank(1'h1);
    u_ldl_ctrl_model.gpulse();
    chk_led(led_exp(1));
    // Latching zeros with outputs lit must darken them mid-cycle.
    u_ldl_ctrl_model.shift(1'b0, '0, PIX_W, 1'b0, seen);
    chk_ser(seen, pv);
    u_ldl_ctrl_model.strobe(1'h1);
    chk_led(24'h00_0000);
    u_ldl_ctrl_model.strobe(1'h0);
    u_ldl_ctrl_model.shift(1'b1, tv, TRIM_W, 1'b0, seen);
    chk_ser(seen & mh, cv & mh);
    chk32({31'h0, correction_serial_out}, {31'h0, tv[TRIM_W-1]},
          "msb");
    chk_vec(ADDR_TSHIFT, tv, '1, 7);
    axi_wr(ADDR_CTRL, 32'h0000_0004, r);
    chk32({30'h0, r}, {30'h0, RESP_OKAY}, "ctrl resp");
    chk_vec(ADDR_TRIM, tv, '1, 7);
    // A write without byte 0 enabled must leave the control bits alone.
    s_axi_wstrb <= 4'h0;
    axi_wr(ADDR_CTRL, 32'h0000_0003, r);
    s_axi_wstrb <= 4'hF;
    axi_rd(ADDR_CTRL, d, r);
    chk32(d, 32'h0000_0000, "ctrl without strobe");
    // Timing reset and auto repeat let blank_n stay high throughout.
    axi_wr(ADDR_CTRL, 32'h0000_0003, r);
    u_ldl_ctrl_model.shift(1'b0, pv, PIX_W, 1'b0, seen);
    chk_ser(seen, '0);
    u_ldl_ctrl_model.strobe(1'h1);
    chk_led(24'h00_0000);
    u_ldl_ctrl_model.gpulse();
    chk_led(led_exp(1));
    repeat (4096) u_ldl_ctrl_model.gpulse();
    chk_led(led_exp(1));
    results();
  end
endmodule
